// ---- inc/apm_pkg.sv ----
// package of constants and types for the alarm pin and interrupt mask block
// What this block does
// - lock-loss pin tristated unless its enable set
// - interrupt enable drives combined pin with interrupt
// - both combined pin enables low tristates it
// - polarity bit 2 sets clock-bad outputs level
// - polarity bit 1 sets lock-loss pin level
// - polarity bit 0 sets interrupt pin level
// - input-loss mask zero lets its flag interrupt
// - crystal-loss mask zero lets its flag interrupt
// - lock-loss mask zero lets its flag interrupt
// - mask writes never alter stored alarm flags
// - pin enable register resets to 0x3e
// - polarity register resets to 0xdf
// - input-loss mask register resets to 0x1f
// - lock-loss mask register resets to 0x3f
package apm_pkg;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam int APM_NREG = 5;
    localparam int APM_IX_PIN_EN = 0;
    localparam int APM_IX_CB_EN = 1;
    localparam int APM_IX_POL = 2;
    localparam int APM_IX_IN_MSK = 3;
    localparam int APM_IX_LK_MSK = 4;

    localparam logic [7:0] APM_REG_OFS [APM_NREG] =
        '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18};
    localparam logic [7:0] APM_REG_RST [APM_NREG] =
        '{8'h3e, 8'h00, 8'hdf, 8'h1f, 8'h3f};
    // writable bits; the rest keep their reset value on write
    localparam logic [7:0] APM_REG_WMSK [APM_NREG] =
        '{8'h03, 8'h01, 8'h07, 8'h03, 8'h01};
    // read-only flags, write one to clear
    localparam logic [7:0] APM_OFS_FLAGS = 8'h7f;
    localparam logic [7:0] APM_RDATA_RST = 8'h00;

    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int APM_BIT_IRQ_PIN = 0;
    localparam int APM_BIT_LK_PIN = 1;
    localparam int APM_BIT_CB_PIN = 0;
    localparam int APM_BIT_IRQ_POL = 0;
    localparam int APM_BIT_LK_POL = 1;
    localparam int APM_BIT_CB_POL = 2;
    localparam int APM_BIT_CX_MSK = 0;
    localparam int APM_BIT_IN_MSK = 1;
    localparam int APM_BIT_LK_MSK = 0;
    localparam int APM_NFLAG = 3;

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic irq_pin_enable;
        logic lock_loss_pin_enable;
        logic clock_bad_pin_enable;
        logic clock_bad_polarity;
        logic lock_loss_polarity;
        logic irq_polarity;
        logic input_loss_mask;
        logic crystal_loss_mask;
        logic lock_loss_mask;
    } apm_cfg_t;

    // bit 2 input loss, bit 1 crystal loss, bit 0 lock loss
    typedef struct packed {
        logic input_loss_flag;
        logic crystal_loss_flag;
        logic lock_loss_flag;
    } apm_alarm_t;

    typedef struct packed {
        logic lock_out;
        logic lock_oe;
        logic icb_out;
        logic icb_oe;
        logic c2b_out;
    } apm_pins_t;

    localparam apm_alarm_t APM_FLAGS_RST = 3'h0;
    localparam apm_pins_t APM_PINS_RST = 5'h00;

endpackage : apm_pkg

// ---- design/apm_alarm_flags.sv ----
// sticky alarm flags with write-one-to-clear and set priority
module apm_alarm_flags
    import apm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // set and clear
    input wire apm_alarm_t set_i,
    input wire apm_alarm_t clr_i,
    // stored flags
    output apm_alarm_t flags_o
);

    // -----------------------------------------------------------------
    // flag storage
    // -----------------------------------------------------------------
    // a set in the clearing cycle wins so no alarm is lost; masks never
    // reach this logic, so masking cannot disturb a stored flag
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flags_o <= APM_FLAGS_RST;
        end else begin
            flags_o <= set_i | (flags_o & ~clr_i);
        end
    end

endmodule : apm_alarm_flags

// ---- design/apm_pin_drive.sv ----
// registered drive of the lock-loss, combined and second clock-bad pins
module apm_pin_drive
    import apm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // configuration and status
    input wire apm_cfg_t cfg_i,
    input wire apm_alarm_t flags_i,
    input wire logic lock_loss_status_i,
    input wire logic clock_bad_i,
    // pin levels and enables
    output apm_pins_t pins_o
);

    logic irq_status;
    apm_pins_t next_pins;

    // -----------------------------------------------------------------
    // interrupt and pin levels
    // -----------------------------------------------------------------
    always_comb begin
        irq_status = (flags_i.input_loss_flag & ~cfg_i.input_loss_mask)
            | (flags_i.crystal_loss_flag & ~cfg_i.crystal_loss_mask)
            | (flags_i.lock_loss_flag & ~cfg_i.lock_loss_mask);
        next_pins = APM_PINS_RST;
        next_pins.lock_oe = cfg_i.lock_loss_pin_enable;
        if (cfg_i.lock_loss_pin_enable) begin
            next_pins.lock_out =
                lock_loss_status_i ~^ cfg_i.lock_loss_polarity;
        end
        if (cfg_i.irq_pin_enable) begin
            next_pins.icb_oe = 1'b1;
            next_pins.icb_out = irq_status ~^ cfg_i.irq_polarity;
        end else if (cfg_i.clock_bad_pin_enable) begin
            next_pins.icb_oe = 1'b1;
            next_pins.icb_out = clock_bad_i ~^ cfg_i.clock_bad_polarity;
        end else begin
            next_pins.icb_oe = 1'b0;
        end
        next_pins.c2b_out = clock_bad_i ~^ cfg_i.clock_bad_polarity;
    end

    // pins come from flops so no decode glitch reaches the board
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pins_o <= APM_PINS_RST;
        end else begin
            pins_o <= next_pins;
        end
    end

endmodule : apm_pin_drive

// ---- design/apm_top.sv ----
// alarm pin enable, polarity and interrupt mask logic with its registers
module apm_top
    import apm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // register access port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // alarm status from the monitors
    input wire logic input_loss_i,
    input wire logic crystal_loss_i,
    input wire logic lock_loss_status_i,
    // alarm pins
    output logic lock_loss_output_o,
    output logic lock_loss_output_oe_o,
    output logic irq_or_clock_bad_output_o,
    output logic irq_or_clock_bad_output_oe_o,
    output logic second_clock_bad_output_o,
    // stored flags
    output apm_alarm_t alarm_flags_o
);

    // -----------------------------------------------------------------
    // address decode
    // -----------------------------------------------------------------
    function automatic logic apm_hit(input logic [7:0] addr,
                                     input logic [7:0] ofs);
        apm_hit = (addr == ofs);
    endfunction : apm_hit

    logic [7:0] reg_q [APM_NREG];
    logic [7:0] next_rdata;
    apm_cfg_t cfg;
    apm_alarm_t flag_set;
    apm_alarm_t flag_clr;
    apm_pins_t pins;
    logic irq_chk;

    // -----------------------------------------------------------------
    // configuration registers
    // -----------------------------------------------------------------
    // reserved bits hold their reset value, so reads show the printed
    // pattern; only the mask bits of each register take new data
    for (genvar g = 0; g < APM_NREG; g++) begin : g_reg
        always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
                reg_q[g] <= APM_REG_RST[g];
            end else if (reg_wr_i && apm_hit(reg_addr_i, APM_REG_OFS[g])) begin
                reg_q[g] <= (reg_wdata_i & APM_REG_WMSK[g])
                    | (reg_q[g] & ~APM_REG_WMSK[g]);
            end
        end
    end

    // field view of the registers for the pin logic
    always_comb begin
        cfg.irq_pin_enable = reg_q[APM_IX_PIN_EN][APM_BIT_IRQ_PIN];
        cfg.lock_loss_pin_enable = reg_q[APM_IX_PIN_EN][APM_BIT_LK_PIN];
        cfg.clock_bad_pin_enable = reg_q[APM_IX_CB_EN][APM_BIT_CB_PIN];
        cfg.clock_bad_polarity = reg_q[APM_IX_POL][APM_BIT_CB_POL];
        cfg.lock_loss_polarity = reg_q[APM_IX_POL][APM_BIT_LK_POL];
        cfg.irq_polarity = reg_q[APM_IX_POL][APM_BIT_IRQ_POL];
        cfg.input_loss_mask = reg_q[APM_IX_IN_MSK][APM_BIT_IN_MSK];
        cfg.crystal_loss_mask = reg_q[APM_IX_IN_MSK][APM_BIT_CX_MSK];
        cfg.lock_loss_mask = reg_q[APM_IX_LK_MSK][APM_BIT_LK_MSK];
    end

    // -----------------------------------------------------------------
    // read path
    // -----------------------------------------------------------------
    // unmapped addresses read as zero
    always_comb begin
        next_rdata = APM_RDATA_RST;
        for (int i = 0; i < APM_NREG; i++) begin
            if (apm_hit(reg_addr_i, APM_REG_OFS[i])) begin
                next_rdata = reg_q[i];
            end
        end
        if (apm_hit(reg_addr_i, APM_OFS_FLAGS)) begin
            next_rdata = {5'h00, alarm_flags_o};
        end
    end

    // data are captured on the read strobe and held until the next one
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= APM_RDATA_RST;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
        end
    end

    // -----------------------------------------------------------------
    // alarm flags
    // -----------------------------------------------------------------
    // flags follow the monitors while they alarm; only the flag register
    // clears them, never a mask write
    always_comb begin
        flag_set.input_loss_flag = input_loss_i;
        flag_set.crystal_loss_flag = crystal_loss_i;
        flag_set.lock_loss_flag = lock_loss_status_i;
        flag_clr = APM_FLAGS_RST;
        if (reg_wr_i && apm_hit(reg_addr_i, APM_OFS_FLAGS)) begin
            flag_clr = reg_wdata_i[APM_NFLAG-1:0];
        end
    end

    apm_alarm_flags u_flags (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .set_i(flag_set),
        .clr_i(flag_clr),
        .flags_o(alarm_flags_o)
    );

    // -----------------------------------------------------------------
    // pin drive
    // -----------------------------------------------------------------
    // the clock-bad status is the live input-loss level of the input
    apm_pin_drive u_pins (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .cfg_i(cfg),
        .flags_i(alarm_flags_o),
        .lock_loss_status_i(lock_loss_status_i),
        .clock_bad_i(input_loss_i),
        .pins_o(pins)
    );

    // straight flop outputs from the pin drive
    assign lock_loss_output_o = pins.lock_out;
    assign lock_loss_output_oe_o = pins.lock_oe;
    assign irq_or_clock_bad_output_o = pins.icb_out;
    assign irq_or_clock_bad_output_oe_o = pins.icb_oe;
    assign second_clock_bad_output_o = pins.c2b_out;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    // independent view of the interrupt, for the checks only
    assign irq_chk = |(alarm_flags_o
        & ~{cfg.input_loss_mask, cfg.crystal_loss_mask, cfg.lock_loss_mask});

    // lock-loss pin released one cycle after its enable is low
    AST_LOCK_PIN_TRI: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !cfg.lock_loss_pin_enable |=> !lock_loss_output_oe_o
    ) else $error("lock-loss pin driven while disabled");

    // enabled lock-loss pin shows status at the chosen level
    AST_LOCK_PIN_SHOW: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        cfg.lock_loss_pin_enable |=> lock_loss_output_oe_o
            && (lock_loss_output_o == ($past(lock_loss_status_i)
                ~^ $past(cfg.lock_loss_polarity)))
    ) else $error("lock-loss pin level wrong");

    // interrupt enable drives the combined pin with the interrupt
    AST_ICB_IRQ: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        cfg.irq_pin_enable |=> irq_or_clock_bad_output_oe_o
            && (irq_or_clock_bad_output_o == ($past(irq_chk)
                ~^ $past(cfg.irq_polarity)))
    ) else $error("combined pin does not show interrupt");

    // interrupt idle level follows polarity bit zero; the idle level is
    // judged in the same cycle as the flags, as a flag may set next cycle
    AST_IRQ_QUIET: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (cfg.irq_pin_enable && !irq_chk)
            |=> irq_or_clock_bad_output_o == !$past(cfg.irq_polarity)
    ) else $error("idle interrupt level wrong");

    // both enables low floats the combined pin
    AST_ICB_TRI: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (!cfg.irq_pin_enable && !cfg.clock_bad_pin_enable)
            |=> !irq_or_clock_bad_output_oe_o
    ) else $error("combined pin driven while both enables low");

    // clock-bad view of the combined pin follows its polarity
    AST_ICB_CB: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (!cfg.irq_pin_enable && cfg.clock_bad_pin_enable)
            |=> irq_or_clock_bad_output_oe_o
            && (irq_or_clock_bad_output_o == ($past(input_loss_i)
                ~^ $past(cfg.clock_bad_polarity)))
    ) else $error("clock-bad level on combined pin wrong");

    // second clock-bad output tracks the input loss level
    AST_C2B: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $changed(input_loss_i) && $stable(cfg.clock_bad_polarity)
            |=> $changed(second_clock_bad_output_o)
    ) else $error("second clock-bad output did not follow");

    // unmasked input-loss alarm asserts the interrupt within two cycles
    AST_MASK_INPUT: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (input_loss_i && !cfg.input_loss_mask && cfg.irq_pin_enable)
            ##1 ($stable(cfg) && !flag_clr.input_loss_flag)
            |=> irq_or_clock_bad_output_o == $past(cfg.irq_polarity)
    ) else $error("input-loss alarm missed the interrupt");

    // unmasked crystal-loss alarm asserts the interrupt
    AST_MASK_XTAL: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (crystal_loss_i && !cfg.crystal_loss_mask && cfg.irq_pin_enable)
            ##1 ($stable(cfg) && !flag_clr.crystal_loss_flag)
            |=> irq_or_clock_bad_output_o == $past(cfg.irq_polarity)
    ) else $error("crystal-loss alarm missed the interrupt");

    // unmasked lock-loss alarm asserts the interrupt
    AST_MASK_LOCK: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (lock_loss_status_i && !cfg.lock_loss_mask && cfg.irq_pin_enable)
            ##1 ($stable(cfg) && !flag_clr.lock_loss_flag)
            |=> irq_or_clock_bad_output_o == $past(cfg.irq_polarity)
    ) else $error("lock-loss alarm missed the interrupt");

    // masked flags alone never raise the interrupt
    AST_MASK_ALL: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (cfg.irq_pin_enable && cfg.input_loss_mask
            && cfg.crystal_loss_mask && cfg.lock_loss_mask)
            |=> irq_or_clock_bad_output_o == !$past(cfg.irq_polarity)
    ) else $error("interrupt raised with every flag masked");

    // mask writes never drop a stored flag
    AST_FLAG_KEEP: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        reg_wr_i && (apm_hit(reg_addr_i, APM_REG_OFS[APM_IX_IN_MSK])
            || apm_hit(reg_addr_i, APM_REG_OFS[APM_IX_LK_MSK]))
            |=> (alarm_flags_o & $past(alarm_flags_o))
                == $past(alarm_flags_o)
    ) else $error("mask write changed a flag");

    // reset values while reset is held
    AST_RST_PIN_EN: assert property (
        @(posedge ref_clk_i)
        rst_i |-> reg_q[APM_IX_PIN_EN] == 8'h3e
    ) else $error("pin enable reset value wrong");

    AST_RST_POL: assert property (
        @(posedge ref_clk_i)
        rst_i |-> reg_q[APM_IX_POL] == 8'hdf
    ) else $error("polarity reset value wrong");

    AST_RST_IN_MSK: assert property (
        @(posedge ref_clk_i)
        rst_i |-> reg_q[APM_IX_IN_MSK] == 8'h1f
    ) else $error("input-loss mask reset value wrong");

    AST_RST_LK_MSK: assert property (
        @(posedge ref_clk_i)
        rst_i |-> reg_q[APM_IX_LK_MSK] == 8'h3f
    ) else $error("lock-loss mask reset value wrong");

endmodule : apm_top

// ---- testbench/apm_host_model.sv ----
// host-side model that watches the lock-loss and combined alarm pins as wires on the board
module apm_host_model
    import apm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // pins as the device drives them
    input wire apm_pins_t pins_i,
    // wire levels as the host sees them
    output logic lock_wire_o,
    output logic icb_wire_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic lock_last_q;
    logic icb_last_q;

    // no pull resistor on either line: a released wire shows the inverse
    // of its last driven level, so a stale sample cannot pass by luck
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lock_last_q <= 1'b0;
            icb_last_q <= 1'b0;
        end else begin
            if (pins_i.lock_oe) begin
                lock_last_q <= pins_i.lock_out;
            end
            if (pins_i.icb_oe) begin
                icb_last_q <= pins_i.icb_out;
            end
        end
    end

    // a driven pin shows its level, a released one the inverted memory
    assign lock_wire_o = pins_i.lock_oe ? pins_i.lock_out : ~lock_last_q;
    assign icb_wire_o = pins_i.icb_oe ? pins_i.icb_out : ~icb_last_q;

endmodule : apm_host_model

// ---- testbench/tb_alarm_pin_and_irq_mask.sv ----
// self-checking bench for the alarm pin and interrupt mask block
module tb_alarm_pin_and_irq_mask
    import apm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    localparam int TIMEOUT_CYC = 20000;
    logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic input_loss_i, crystal_loss_i, lock_loss_status_i;
    logic lock_loss_output_o, lock_loss_output_oe_o;
    logic irq_or_clock_bad_output_o, irq_or_clock_bad_output_oe_o;
    logic second_clock_bad_output_o, lock_wire, icb_wire;
    apm_alarm_t alarm_flags_o, fl;
    apm_pins_t pins_seen;
    logic [7:0] sh [APM_NREG];
    logic [31:0] r;
    integer seed;
    int n_mismatch, checks_done;
    int cycles = 0;

    assign pins_seen = {lock_loss_output_o, lock_loss_output_oe_o,
        irq_or_clock_bad_output_o, irq_or_clock_bad_output_oe_o,
        second_clock_bad_output_o};

    apm_top apm_top_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .input_loss_i(input_loss_i), .crystal_loss_i(crystal_loss_i),
        .lock_loss_status_i(lock_loss_status_i),
        .lock_loss_output_o(lock_loss_output_o),
        .lock_loss_output_oe_o(lock_loss_output_oe_o),
        .irq_or_clock_bad_output_o(irq_or_clock_bad_output_o),
        .irq_or_clock_bad_output_oe_o(irq_or_clock_bad_output_oe_o),
        .second_clock_bad_output_o(second_clock_bad_output_o),
        .alarm_flags_o(alarm_flags_o)
    );

    apm_host_model apm_host_model_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pins_i(pins_seen),
        .lock_wire_o(lock_wire), .icb_wire_o(icb_wire)
    );

    // ---------------------------------------------------------------
    // clock and hang guard
    // ---------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    // a stuck handshake would otherwise run forever
    always @(posedge ref_clk_i) begin
        cycles = cycles + 1;
        if (cycles == TIMEOUT_CYC) begin
            n_mismatch = n_mismatch + 1;
            final_report();
        end
    end

    // ---------------------------------------------------------------
    // tasks and expectations
    // ---------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // every task starts and ends just after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : step

    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        reg_addr_i = addr;
        reg_wdata_i = data;
        reg_wr_i = 1'b1;
        step(1);
        reg_wr_i = 1'b0;
        // an idle edge keeps a following strobe out of this time step
        step(1);
    endtask : wr_reg

    // read data counts only with its valid pulse in the same cycle
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        reg_addr_i = addr;
        reg_rd_i = 1'b1;
        step(1);
        reg_rd_i = 1'b0;
        check((reg_rvalid_o === 1'b1) ? reg_rdata_o : 8'hxx, exp);
        step(1);
    endtask : rd_chk

    // shadow copy: reserved bits keep their reset pattern
    task automatic cfg(input int ix, input logic [7:0] data);
        wr_reg(APM_REG_OFS[ix], data);
        sh[ix] = (APM_REG_RST[ix] & ~APM_REG_WMSK[ix])
            | (data & APM_REG_WMSK[ix]);
    endtask : cfg

    task automatic alarms(input logic [2:0] a);
        {input_loss_i, crystal_loss_i, lock_loss_status_i} = a;
    endtask : alarms

    function automatic apm_pins_t exp_pins(input apm_alarm_t f,
                                           input logic lk, input logic inl);
        apm_pins_t p;
        logic irq;
        logic [7:0] pe, pol;
        pe = sh[APM_IX_PIN_EN];
        pol = sh[APM_IX_POL];
        irq = (f.input_loss_flag & ~sh[APM_IX_IN_MSK][1])
            | (f.crystal_loss_flag & ~sh[APM_IX_IN_MSK][0])
            | (f.lock_loss_flag & ~sh[APM_IX_LK_MSK][0]);
        p.lock_oe = pe[1];
        p.lock_out = pe[1] & (pol[1] ? lk : ~lk);
        p.icb_oe = pe[0] | sh[APM_IX_CB_EN][0];
        p.icb_out = pe[0] ? (pol[0] ? irq : ~irq)
            : (sh[APM_IX_CB_EN][0] & (pol[2] ? inl : ~inl));
        p.c2b_out = pol[2] ? inl : ~inl;
        return p;
    endfunction : exp_pins

    task automatic chk_all(input apm_alarm_t f, input logic lk,
                           input logic inl);
        apm_pins_t e;
        e = exp_pins(f, lk, inl);
        check({3'h0, pins_seen}, {3'h0, e});
        if (e.lock_oe) check({7'h0, lock_wire}, {7'h0, e.lock_out});
        if (e.icb_oe) check({7'h0, icb_wire}, {7'h0, e.icb_out});
    endtask : chk_all

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        seed = 32'h8d49_2c98;
        n_mismatch = 0;
        checks_done = 0;
        rst_i = 1'b1;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        alarms(3'h0);
        for (int i = 0; i < APM_NREG; i++) sh[i] = APM_REG_RST[i];
        repeat (10) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        // reset values and the pins they select
        rd_chk(8'h14, 8'h3e);
        rd_chk(8'h16, 8'hdf);
        rd_chk(8'h17, 8'h1f);
        rd_chk(8'h18, 8'h3f);
        rd_chk(8'h30, 8'h00);
        step(2);
        chk_all(3'h0, 1'b0, 1'b0);
        // writable and reserved bits of every register
        for (int ix = 0; ix < APM_NREG; ix++) begin
            cfg(ix, 8'hff);
            rd_chk(APM_REG_OFS[ix], sh[ix]);
            cfg(ix, 8'h00);
            rd_chk(APM_REG_OFS[ix], sh[ix]);
        end
        // each flag alone, unmasked then masked, interrupt on the pin
        cfg(APM_IX_PIN_EN, 8'h03);
        cfg(APM_IX_POL, 8'h07);
        for (int b = 0; b < 3; b++) begin
            cfg(APM_IX_IN_MSK, 8'h00);
            cfg(APM_IX_LK_MSK, 8'h00);
            wr_reg(APM_OFS_FLAGS, 8'h07);
            step(3);
            fl = apm_alarm_t'(3'b001 << b);
            alarms(fl);
            step(3);
            chk_all(fl, fl[0], fl[2]);
            alarms(3'h0);
            cfg(APM_IX_IN_MSK, 8'h03);
            cfg(APM_IX_LK_MSK, 8'h01);
            step(3);
            check({5'h00, alarm_flags_o}, {5'h00, fl});
            chk_all(fl, 1'b0, 1'b0);
        end
        // random settings and alarm patterns
        for (int it = 0; it < 40; it++) begin
            alarms(3'h0);
            wr_reg(APM_OFS_FLAGS, 8'h07);
            step(3);
            check({5'h00, alarm_flags_o}, 8'h00);
            r = $random(seed);
            fl = r[2:0];
            alarms(fl);
            for (int ix = 0; ix < APM_NREG; ix++) begin
                r = $random(seed);
                cfg(ix, r[7:0]);
            end
            step(3);
            chk_all(fl, fl[0], fl[2]);
            rd_chk(APM_OFS_FLAGS, {5'h00, fl});
            // masks rewritten with the alarms gone: flags must stay
            alarms(3'h0);
            r = $random(seed);
            cfg(APM_IX_IN_MSK, r[7:0]);
            cfg(APM_IX_LK_MSK, r[15:8]);
            step(3);
            check({5'h00, alarm_flags_o}, {5'h00, fl});
            chk_all(fl, 1'b0, 1'b0);
        end
        final_report();
    end

endmodule : tb_alarm_pin_and_irq_mask
